// *** srs_pkg.sv ***
// Shared constants and types for the scan range code and status output block
package srs_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int SYNC_PULSE_US = 1000;
	localparam int SYNC_PULSE_CYC = (SYNC_PULSE_US * (CLK_HZ / 1_000_000));
	localparam int BLINK_MALF_MS = 1000;
	localparam int BLINK_SLEEP_MS = 4000;
	localparam int BLINK_START_MS = 250;
	localparam int SETTLE_US = 100;
	localparam int MS_CYC = CLK_HZ / 1000;
	localparam int BLINK_MALF_CYC = BLINK_MALF_MS * MS_CYC;
	localparam int BLINK_SLEEP_CYC = BLINK_SLEEP_MS * MS_CYC;
	localparam int BLINK_START_CYC = BLINK_START_MS * MS_CYC;
	localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);

	// ------------------------------------------------------------
	// Measurement codes
	// ------------------------------------------------------------
	localparam int RAW_W = 20;
	localparam int CODE_W = 18;
	localparam int LEVEL_W = 16;
	localparam int ECHOES = 3;
	localparam logic [CODE_W-1:0] CODE_NO_ECHO = 18'h3fffc;
	localparam logic [CODE_W-1:0] CODE_SHORT = 18'h3fffe;
	localparam logic [CODE_W-1:0] CODE_LONG = 18'h3ffff;
	localparam logic [RAW_W-1:0] DIST_MIN = 20'h00023;
	localparam logic [RAW_W-1:0] DIST_MAX = 20'h0ea60;

	// ------------------------------------------------------------
	// Register map (byte offsets) and fields
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_SECTOR = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_ECHO0 = 4'hc;
	localparam int CTRL_AREA_MODE = 0;
	localparam int CTRL_CONT_EN = 1;
	localparam int CTRL_CONT_PART = 2;
	localparam int CTRL_DET_INV = 3;
	localparam int CTRL_SLEEP = 4;
	localparam int CTRL_ADDR_INIT = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	localparam int STEP_W = 11;
	localparam int SECT_END_LSB = 16;
	localparam logic [31:0] SECTOR_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// Sensor state, Gray coded along the usual path
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SRS_STARTUP = 3'b000,
		SRS_OPERATE = 3'b001,
		SRS_SLEEP = 3'b011,
		SRS_ADDR_INIT = 3'b010,
		SRS_MALF = 3'b110
	} srs_state_e;

endpackage : srs_pkg

// *** srs_range_enc.sv ***
// Encoder of one echo's raw range into a measurement code
`timescale 1ns/10ps
module srs_range_enc
	import srs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic step_strobe,
	input wire logic echo_en,
	input wire logic area_mode,
	input wire logic hit,
	input wire logic level_ok,
	input wire logic limited_zone,
	input wire logic [RAW_W-1:0] raw_mm,
	input wire logic [LEVEL_W-1:0] raw_level,
	output logic [CODE_W-1:0] code,
	output logic [LEVEL_W-1:0] level
);

	logic no_echo;
	logic too_short;
	logic too_long;
	logic [CODE_W-1:0] next_code;
	logic [LEVEL_W-1:0] next_level;

	// Echoes beyond the first are absent in area mode
	assign no_echo = !echo_en || !hit || !level_ok;
	assign too_short = area_mode ? limited_zone : (raw_mm < DIST_MIN);
	assign too_long = raw_mm > DIST_MAX;
	assign next_code = no_echo ? CODE_NO_ECHO :
		too_short ? CODE_SHORT :
		too_long ? CODE_LONG :
		raw_mm[CODE_W-1:0];
	assign next_level = no_echo ? '0 : raw_level;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			code <= CODE_NO_ECHO;
			level <= '0;
		end else if (step_strobe) begin
			code <= next_code;
			level <= next_level;
		end
	end

endmodule : srs_range_enc

// *** srs_blink.sv ***
// Square-wave blinker for the power indicator, toggling every HALF cycles
`timescale 1ns/10ps
module srs_blink #(
	parameter int HALF = 40_000_000
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic run,
	output logic led
);

	logic [31:0] cnt;
	logic wrap;

	assign wrap = cnt >= 32'(HALF - 1);

	// Idle blinker rests on, so a fresh start begins with a lit phase
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= '0;
			led <= 1'b1;
		end else if (!run) begin
			cnt <= '0;
			led <= 1'b1;
		end else if (wrap) begin
			cnt <= '0;
			led <= !led;
		end else begin
			cnt <= cnt + 32'd1;
		end
	end

endmodule : srs_blink

// *** srs_top.sv ***
// Scan range coder, status lines, indicators and register slave
//
// Contract
// - Range 35..60000 reported as millimetres
// - No echo gives 3FFFC, level zero
// - Too close or limited zone gives 3FFFE; code uses limited zone only in area mode, too close only outside it
// - Beyond 60000 mm gives 3FFFF
// - Operating: ready, malfunction high; 1 ms sync
// - Orange indicator off in coordinate mode
// - Output levels undefined shortly after power-up
// - Detection polarity by setting; default low
// - Coordinate mode delivers up to three echoes
// - Enabled contamination warning drops ready line
// - Contamination never stops scan nor faults
// - Partial mode: sector, sensing plus short range
// - Full mode: whole window, internal sensing only
// - Laser/motor fault: malfunction low, stop both
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module srs_top
	import srs_pkg::*;
#(
	parameter int SYNC_CYC = SYNC_PULSE_CYC,
	parameter int MALF_HALF = BLINK_MALF_CYC,
	parameter int SLEEP_HALF = BLINK_SLEEP_CYC,
	parameter int START_HALF = BLINK_START_CYC,
	parameter int SETTLE = SETTLE_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic startup_done,
	input wire logic laser_fault,
	input wire logic motor_fault,
	input wire logic motor_unstable,
	input wire logic scan_start,
	input wire logic step_strobe,
	input wire logic [STEP_W-1:0] step_index,
	input wire logic [ECHOES-1:0] echo_hit,
	input wire logic [ECHOES-1:0] echo_level_ok,
	input wire logic limited_zone,
	input wire logic [ECHOES*RAW_W-1:0] echo_raw_mm,
	input wire logic [ECHOES*LEVEL_W-1:0] echo_raw_level,
	input wire logic cont_sense_step,
	input wire logic cont_sense_all,
	input wire logic [2:0] area_detect,
	output logic [ECHOES*CODE_W-1:0] echo_code,
	output logic [ECHOES*LEVEL_W-1:0] echo_level,
	output logic ready_line,
	output logic malf_line,
	output logic sync_line,
	output logic [2:0] detect_line,
	output logic power_led,
	output logic orange_led,
	output logic laser_en,
	output logic motor_en,
	output logic lines_valid
);

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	srs_state_e state;
	srs_state_e next_state;
	logic [CTRL_W-1:0] ctrl;
	logic [31:0] sector;
	logic ack;
	logic [31:0] next_readdata;
	logic [31:0] sync_cnt;
	logic [31:0] settle_cnt;
	logic part_seen;
	logic part_warn;
	logic fault;

	wire area_mode = ctrl[CTRL_AREA_MODE];
	wire cont_en = ctrl[CTRL_CONT_EN];
	wire cont_part = ctrl[CTRL_CONT_PART];
	wire det_inv = ctrl[CTRL_DET_INV];
	wire operating = state == SRS_OPERATE;

	// Byte-lane merge, shared by both writable registers
	function automatic logic [31:0] srs_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : srs_merge

	// ------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then the answer
	// ------------------------------------------------------------
	wire req = avs_read || avs_write;
	wire wr_go = avs_write && ack;
	wire hit_ctrl = avs_address == REG_CTRL;
	wire hit_sector = avs_address == REG_SECTOR;
	wire [31:0] ctrl_wide = {{(32-CTRL_W){1'b0}}, ctrl};
	wire [31:0] ctrl_new = srs_merge(ctrl_wide, avs_writedata, avs_byteenable);
	wire [31:0] sector_new = srs_merge(sector, avs_writedata, avs_byteenable);
	wire [31:0] status_word = {22'h000000, fault, part_warn, cont_sense_all,
		lines_valid, malf_line, ready_line, 1'b0, state};

	assign avs_waitrequest = req && !ack;

	always_comb begin
		unique case (avs_address)
			REG_CTRL: next_readdata = ctrl_wide;
			REG_SECTOR: next_readdata = sector;
			REG_STATUS: next_readdata = status_word;
			REG_ECHO0: next_readdata = {14'h0000, echo_code[CODE_W-1:0]};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack <= req && !ack;
			if (avs_read && !ack) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	// Polarity and modes only change through software settings
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= CTRL_RESET;
			sector <= SECTOR_RESET;
		end else if (wr_go) begin
			if (hit_ctrl) begin
				ctrl <= ctrl_new[CTRL_W-1:0];
			end
			if (hit_sector) begin
				sector <= sector_new;
			end
		end
	end

	// ------------------------------------------------------------
	// Range encoders, one per echo
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ECHOES; g++) begin : g_echo
			srs_range_enc u_enc (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.step_strobe(step_strobe),
				.echo_en(g == 0 || !area_mode),
				.area_mode(area_mode),
				.hit(echo_hit[g]),
				.level_ok(echo_level_ok[g]),
				.limited_zone(limited_zone),
				.raw_mm(echo_raw_mm[g*RAW_W +: RAW_W]),
				.raw_level(echo_raw_level[g*LEVEL_W +: LEVEL_W]),
				.code(echo_code[g*CODE_W +: CODE_W]),
				.level(echo_level[g*LEVEL_W +: LEVEL_W])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Sensor state
	// ------------------------------------------------------------
	// A fault is final until nrst resets the state; a restart might fire a bad laser
	always_comb begin
		next_state = state;
		unique case (state)
			SRS_STARTUP: begin
				if (startup_done) begin
					next_state = SRS_OPERATE;
				end
			end
			SRS_OPERATE: begin
				if (ctrl[CTRL_SLEEP]) begin
					next_state = SRS_SLEEP;
				end else if (ctrl[CTRL_ADDR_INIT]) begin
					next_state = SRS_ADDR_INIT;
				end
			end
			SRS_SLEEP: begin
				if (!ctrl[CTRL_SLEEP]) begin
					next_state = SRS_OPERATE;
				end
			end
			SRS_ADDR_INIT: begin
				if (!ctrl[CTRL_ADDR_INIT]) begin
					next_state = SRS_OPERATE;
				end
			end
			SRS_MALF: next_state = SRS_MALF;
			default: next_state = SRS_MALF;
		endcase
		if (laser_fault || motor_fault) begin
			next_state = SRS_MALF;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= SRS_STARTUP;
		end else begin
			state <= next_state;
		end
	end

	assign fault = state == SRS_MALF;
	assign laser_en = !fault;
	assign motor_en = !fault;

	// ------------------------------------------------------------
	// Contamination warning
	// ------------------------------------------------------------
	// Partial mode judges one scan at a time, so one dirty scan flags it
	wire [STEP_W-1:0] sect_lo = sector[STEP_W-1:0];
	wire [STEP_W-1:0] sect_hi = sector[SECT_END_LSB +: STEP_W];
	wire in_sector = step_index >= sect_lo && step_index <= sect_hi;
	wire short_hit = echo_hit[0] && echo_raw_mm[RAW_W-1:0] < DIST_MIN;
	wire part_step = step_strobe && in_sector && cont_sense_step && short_hit;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			part_seen <= 1'b0;
			part_warn <= 1'b0;
		end else if (scan_start) begin
			part_warn <= part_seen || part_step;
			part_seen <= 1'b0;
		end else if (part_step) begin
			part_seen <= 1'b1;
		end
	end

	wire cont_level = cont_part ? part_warn : cont_sense_all;
	wire cont_warn = cont_en && cont_level;

	// ------------------------------------------------------------
	// Synchronisation pulse
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync_cnt <= '0;
		end else if (!operating) begin
			sync_cnt <= '0;
		end else if (scan_start) begin
			sync_cnt <= 32'(SYNC_CYC);
		end else if (sync_cnt != '0) begin
			sync_cnt <= sync_cnt - 32'd1;
		end
	end

	// ------------------------------------------------------------
	// Power-up settle window
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			settle_cnt <= '0;
			lines_valid <= 1'b0;
		end else if (settle_cnt >= 32'(SETTLE - 1)) begin
			lines_valid <= 1'b1;
		end else begin
			settle_cnt <= settle_cnt + 32'd1;
		end
	end

	// ------------------------------------------------------------
	// Output lines and indicators
	// ------------------------------------------------------------
	// Contamination only touches ready; scanning and sync carry on
	assign ready_line = operating && !cont_warn && !motor_unstable;
	assign malf_line = !fault;
	assign sync_line = !(operating && sync_cnt != '0);

	wire [2:0] det_level = det_inv ? area_detect : ~area_detect;
	assign detect_line = (operating && area_mode) ? det_level : 3'b000;

	wire orange_state = operating ? (|area_detect) : (state != SRS_SLEEP);
	assign orange_led = area_mode && orange_state;

	logic blink_start;
	logic blink_malf;
	logic blink_sleep;

	srs_blink #(.HALF(START_HALF)) u_blink_start (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.run(state == SRS_STARTUP),
		.led(blink_start)
	);

	srs_blink #(.HALF(MALF_HALF)) u_blink_malf (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.run(fault),
		.led(blink_malf)
	);

	srs_blink #(.HALF(SLEEP_HALF)) u_blink_sleep (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.run(state == SRS_SLEEP),
		.led(blink_sleep)
	);

	assign power_led = blink_start && blink_malf && blink_sleep;

endmodule : srs_top

// *** srs_chk.sv ***
// Checker of the range coder, status lines and bus answer timing
`timescale 1ns/10ps
module srs_chk
	import srs_pkg::*;
#(
	parameter int SYNC_CYC = 20,
	parameter int SETTLE = 5
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic avs_read,
	input wire logic avs_write,
	input logic avs_waitrequest,
	input wire logic laser_fault,
	input wire logic motor_fault,
	input wire logic scan_start,
	input wire logic step_strobe,
	input wire logic [ECHOES-1:0] echo_hit,
	input wire logic [ECHOES-1:0] echo_level_ok,
	input wire logic limited_zone,
	input wire logic [ECHOES*RAW_W-1:0] echo_raw_mm,
	input logic [ECHOES*CODE_W-1:0] echo_code,
	input logic [ECHOES*LEVEL_W-1:0] echo_level,
	input logic ready_line,
	input logic malf_line,
	input logic sync_line,
	input logic [2:0] detect_line,
	input logic power_led,
	input logic laser_en,
	input logic motor_en,
	input logic lines_valid
);
	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [15:0] low_cnt;
	logic [15:0] up_cnt;
	logic ok0;
	logic [19:0] r0;
	assign ok0 = step_strobe && echo_hit[0] && echo_level_ok[0];
	assign r0 = echo_raw_mm[19:0];
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			low_cnt <= 16'h0000;
			up_cnt <= 16'h0000;
		end else begin
			low_cnt <= sync_line ? 16'h0000 : low_cnt + 16'h0001;
			up_cnt <= (up_cnt == 16'hffff) ? up_cnt : up_cnt + 16'h0001;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	// Blink interval of eight cycles, as set for the bench
	sequence s_half;
		$stable(power_led)[*7] ##1 $changed(power_led);
	endsequence
	sequence s_sync_low;
		(!sync_line)[*8];
	endsequence
	a_code_in_range: assert property (ok0 && !limited_zone && r0 >= DIST_MIN
		&& r0 <= DIST_MAX |=> echo_code[17:0] == $past(r0[17:0]))
		else $error("echo0 in range code wrong");
	a_code_no_echo: assert property (step_strobe && !ok0 |=>
		echo_code[17:0] == CODE_NO_ECHO && echo_level[15:0] == 16'h0000)
		else $error("echo0 no echo code wrong");
	a_code_long: assert property (ok0 && !limited_zone && r0 > DIST_MAX
		|=> echo_code[17:0] == CODE_LONG)
		else $error("echo0 long code wrong");
	a_sync_start: assert property (scan_start && sync_line && ready_line
		&& malf_line |=> s_sync_low)
		else $error("sync pulse missing");
	a_sync_width: assert property ($rose(sync_line) && malf_line
		|-> low_cnt == SYNC_CYC)
		else $error("sync pulse width wrong");
	a_settle_low: assert property (up_cnt < SETTLE |-> !lines_valid)
		else $error("lines valid too early");
	a_valid_late: assert property (up_cnt == SETTLE + 2 |-> lines_valid)
		else $error("lines valid late");
	a_fault_stop: assert property (laser_fault || motor_fault |=>
		!malf_line && !laser_en && !motor_en)
		else $error("fault did not stop");
	a_safe_lines: assert property (!malf_line |-> !ready_line && sync_line
		&& detect_line == 3'b000)
		else $error("fault line levels wrong");
	a_malf_blink: assert property (!malf_line && $changed(power_led)
		|=> s_half)
		else $error("fault blink interval wrong");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest)
		else $error("bus answer late");
endmodule : srs_chk

bind srs_top srs_chk #(.SYNC_CYC(SYNC_CYC), .SETTLE(SETTLE)) i_srs_chk (
	.sys_clk, .nrst, .avs_read, .avs_write, .avs_waitrequest, .laser_fault,
	.motor_fault, .scan_start, .step_strobe, .echo_hit, .echo_level_ok,
	.limited_zone, .echo_raw_mm, .echo_code, .echo_level, .ready_line,
	.malf_line, .sync_line, .detect_line, .power_led, .laser_en, .motor_en,
	.lines_valid
);

// *** srs_host.sv ***
// Host model: register bus master of the controller
`timescale 1ns/10ps
module srs_host (
	input wire logic sys_clk,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	output logic [3:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable
);
	initial begin
		avs_address <= 4'h0;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h0;
		avs_byteenable <= 4'hf;
	end
	// Request held until an edge samples waitrequest low; data taken there
	task xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		n = 0;
		q = 32'h0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 40) begin
			n++;
			@(posedge sys_clk);
		end
		q = avs_readdata;
		ok = (n < 40);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer
endmodule : srs_host

// *** tb_srs_top.sv ***
// Testbench of the scan range coder and status lines
`timescale 1ns/10ps
module tb_srs_top;
	import srs_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] avs_address, avs_byteenable;
	logic avs_read, avs_write, avs_waitrequest, startup_done, laser_fault;
	logic [31:0] avs_writedata, avs_readdata;
	logic scan_start, step_strobe, limited_zone, cont_sense_step;
	logic cont_sense_all, ready_line, malf_line, sync_line, power_led;
	logic orange_led, laser_en, motor_en, lines_valid;
	logic motor_fault, motor_unstable;
	logic [STEP_W-1:0] step_index;
	logic [2:0] echo_hit, echo_level_ok, area_detect, detect_line, h;
	logic [59:0] echo_raw_mm, mm;
	logic [47:0] echo_raw_level, echo_level;
	logic [53:0] echo_code;
	logic [RAW_W-1:0] tr[6];
	logic [CODE_W-1:0] tc[6];
	logic [5:0] th = 6'h2f;
	logic [5:0] tl = 6'h1f;
	int n_errors = 0;
	int comparisons = 0;
	int k[3];
	int n;
	always #12.5 sys_clk = ~sys_clk;
	srs_top #(.SYNC_CYC(20), .MALF_HALF(8), .SLEEP_HALF(16), .START_HALF(4),
		.SETTLE(5)) i_srs_top (.sys_clk, .nrst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .startup_done, .laser_fault, .motor_fault,
		.motor_unstable, .scan_start, .step_strobe, .step_index,
		.echo_hit, .echo_level_ok, .limited_zone, .echo_raw_mm, .echo_raw_level,
		.cont_sense_step, .cont_sense_all, .area_detect, .echo_code,
		.echo_level, .ready_line, .malf_line, .sync_line, .detect_line,
		.power_led, .orange_led, .laser_en, .motor_en, .lines_valid);
	srs_host i_srs_host (.sys_clk, .avs_readdata, .avs_waitrequest,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task finish_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	task chk(input string s, input logic [31:0] e, input logic [31:0] v);
		comparisons++;
		if (v !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, v);
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic ok;
		i_srs_host.xfer(w, a, d, q, ok);
		if (!ok) begin
			n_errors++;
			finish_test();
		end else if (!w)
			chk("reg", d, q);
	endtask : bus
	task step(input logic [2:0] hh, input logic [2:0] ll);
		@(posedge sys_clk);
		echo_raw_mm <= mm;
		echo_hit <= hh;
		echo_level_ok <= ll;
		step_strobe <= 1'b1;
		@(posedge sys_clk);
		step_strobe <= 1'b0;
		@(negedge sys_clk);
	endtask : step
	task scan;
		@(posedge sys_clk);
		scan_start <= 1'b1;
		@(posedge sys_clk);
		scan_start <= 1'b0;
		n = 0;
		@(negedge sys_clk);
		while (sync_line === 1'b0 && n < 100) begin
			n++;
			@(negedge sys_clk);
		end
	endtask : scan
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		finish_test();
	end
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		tr = '{DIST_MIN, DIST_MAX, DIST_MIN - 20'h1, DIST_MAX + 20'h1,
			20'h001f4, 20'h002bc};
		tc = '{18'h0, 18'h0, CODE_SHORT, CODE_LONG, CODE_NO_ECHO, CODE_NO_ECHO};
		{startup_done, laser_fault, scan_start, step_strobe} = 4'h0;
		{limited_zone, cont_sense_step, cont_sense_all} = 3'h0;
		{motor_fault, motor_unstable} = 2'h0;
		{echo_hit, echo_level_ok, area_detect} = 9'h000;
		step_index = 11'h000;
		echo_raw_mm = 60'h0;
		echo_raw_level = 48'h3333_2222_1111;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		@(negedge sys_clk);
		chk("ready", 32'h0, 32'(ready_line));
		chk("sync", 32'h1, 32'(sync_line));
		@(posedge sys_clk);
		startup_done <= 1'b1;
		area_detect <= 3'b111;
		repeat (10) @(negedge sys_clk);
		chk("ready", 32'h1, 32'(ready_line));
		chk("malf", 32'h1, 32'(malf_line));
		chk("orange", 32'h0, 32'(orange_led));
		chk("valid", 32'h1, 32'(lines_valid));
		scan();
		chk("sync_len", 32'd20, 32'(n));
		for (int i = 0; i < 6; i++) begin
			for (int g = 0; g < 3; g++) begin
				k[g] = (i + g) % 6;
				mm[g*20 +: 20] = tr[k[g]];
				h[g] = th[k[g]];
			end
			step(h, {tl[k[2]], tl[k[1]], tl[k[0]]});
			for (int g = 0; g < 3; g++) begin
				chk("code", 32'(k[g] < 2 ? tr[k[g]][17:0] : tc[k[g]]),
					32'(echo_code[g*18 +: 18]));
				if (k[g] < 2 || k[g] > 3)
					chk("level", 32'(k[g] > 3 ? 16'h0 : echo_raw_level[g*16 +: 16]),
						32'(echo_level[g*16 +: 16]));
			end
		end
		bus(1'b1, REG_CTRL, 32'h1);
		limited_zone <= 1'b1;
		mm = 60'h3e8_003e8;
		step(3'b011, 3'b011);
		chk("area0", 32'(CODE_SHORT), 32'(echo_code[17:0]));
		chk("area1", 32'(CODE_NO_ECHO), 32'(echo_code[35:18]));
		@(posedge sys_clk);
		limited_zone <= 1'b0;
		area_detect <= 3'b101;
		@(negedge sys_clk);
		chk("detect", 32'h2, 32'(detect_line));
		bus(1'b1, REG_CTRL, 32'h9);
		@(negedge sys_clk);
		chk("detect", 32'h5, 32'(detect_line));
		bus(1'b0, REG_CTRL, 32'h9);
		bus(1'b0, 4'h1, 32'h0);
		bus(1'b1, REG_CTRL, 32'h2);
		cont_sense_all <= 1'b1;
		scan();
		chk("ready", 32'h0, 32'(ready_line));
		chk("malf", 32'h1, 32'(malf_line));
		chk("sync_len", 32'd20, 32'(n));
		cont_sense_all <= 1'b0;
		bus(1'b1, REG_SECTOR, 32'h0014_000a);
		bus(1'b1, REG_CTRL, 32'h6);
		cont_sense_step <= 1'b1;
		step_index <= 11'h01e;
		mm = 60'h14;
		scan();
		step(3'b001, 3'b001);
		scan();
		chk("ready", 32'h1, 32'(ready_line));
		step_index <= 11'h00f;
		step(3'b001, 3'b001);
		scan();
		chk("ready", 32'h0, 32'(ready_line));
		bus(1'b1, REG_CTRL, 32'h10);
		repeat (2) @(negedge sys_clk);
		chk("ready", 32'h0, 32'(ready_line));
		chk("lines", 32'h6, {29'h0, sync_line, malf_line, orange_led});
		chk("detect", 32'h0, 32'(detect_line));
		bus(1'b0, REG_STATUS, 32'h163);
		bus(1'b0, REG_ECHO0, 32'h3fffe);
		bus(1'b1, REG_CTRL, 32'h20);
		repeat (3) @(negedge sys_clk);
		chk("ready", 32'h0, 32'(ready_line));
		chk("power", 32'h1, 32'(power_led));
		bus(1'b1, REG_CTRL, 32'h0);
		repeat (2) @(negedge sys_clk);
		chk("ready", 32'h1, 32'(ready_line));
		motor_unstable <= 1'b1;
		@(negedge sys_clk);
		chk("ready", 32'h0, 32'(ready_line));
		chk("malf", 32'h1, 32'(malf_line));
		motor_unstable <= 1'b0;
		@(posedge sys_clk);
		laser_fault <= 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("stop", 32'h4, {29'h0, sync_line, laser_en, motor_en});
		chk("malf", 32'h0, 32'(malf_line));
		repeat (30) @(posedge sys_clk);
		laser_fault <= 1'b0;
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("ready", 32'h1, 32'(ready_line));
		@(posedge sys_clk);
		motor_fault <= 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("stop", 32'h4, {29'h0, sync_line, laser_en, motor_en});
		chk("malf", 32'h0, 32'(malf_line));
		repeat (30) @(posedge sys_clk);
		finish_test();
	end
endmodule : tb_srs_top
